// ===== sie_top.sv
// Safety input evaluation top: filters, simultaneity, reset, fieldbus inputs, registers
// What this block does
// - In grip mode the output is high only while the grip is held in its middle position.
// - A simultaneity error is flagged when the contacts of one device switch further apart than allowed.
// - With reset selected each release of the device locks the output until a reset, otherwise it follows the inputs.
// - Manual reset is accepted on one rising edge of the reset input.
// - Monitored reset is accepted only after the reset input rises and falls again.
// - With the power-on test the output stays off until the device is activated and released once after start-up.
// - Each input passes a debounce filter of 3 to 250 ms.
// - The testable device checks simultaneity only when that option is on.
// - The solid-state device outputs one only when all its inputs are active.
// - The solid-state device always checks simultaneity.
// - With the error output enabled a fault of the block drives the fault output.
// - Up to 32 virtual inputs on the extended master or 8 on the basic master, one bit each.
// - Virtual inputs arrive as a 4-byte field for the extended master and a 1-byte field for the basic one.
// - A constant low source and a high source that rises at the first clock after reset are provided and are not meant to disable logic gates.
//
// Added by the designer: the register addresses and the address-and-strobe port.
module sie_top
    import sie_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic contact_input_a,
    input wire logic contact_input_b,
    input wire logic contact_input_c,
    input wire logic reset_input,
    input wire logic fb_wr,
    input wire logic [31:0] fb_data,
    output logic block_out,
    output logic fault_out,
    output logic irq,
    output logic [31:0] vin_out,
    output logic const_low_source,
    output logic const_high_source
);
    logic [NUM_IN-1:0] raw_in;
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic [NUM_IN-1:0] filt;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick_cnt;
    logic tick;
    logic next_tick;
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [7:0] filter_ms;
    logic [7:0] next_filter_ms;
    logic [7:0] filter_eff;
    logic [SIMUL_W-1:0] simul_ms;
    logic [SIMUL_W-1:0] next_simul_ms;
    logic [SIMUL_W-1:0] simul_cnt;
    logic [SIMUL_W-1:0] next_simul_cnt;
    logic simul_fault;
    logic next_simul_fault;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] next_status;
    logic [EV_W-1:0] mask;
    logic [EV_W-1:0] next_mask;
    logic [EV_W-1:0] events;
    logic [31:0] next_rdata;
    logic [31:0] next_vin;
    sie_state_t state;
    sie_state_t next_state;
    logic next_block_out;
    logic next_fault_out;
    logic next_irq;
    logic cond;
    logic simul_active;
    logic reset_accept;

    // Decode used by both the write and the read path
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Contact order a, b, c, then reset on the following input
    assign raw_in = {reset_input, contact_input_c, contact_input_b, contact_input_a};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
            sie_debounce u_deb (
                .core_clk(core_clk),
                .rst(rst),
                .tick(tick),
                .filter_ms(filter_eff),
                .din(sync2[gi]),
                .dout(filt[gi])
            );
        end
    endgenerate

    // Out-of-range settings are clamped rather than refused
    assign filter_eff = (filter_ms < FILTER_MIN) ? FILTER_MIN :
                        (filter_ms > FILTER_MAX) ? FILTER_MAX : filter_ms;

    sie_reset_ctl u_rst (
        .core_clk(core_clk),
        .rst(rst),
        .monitored(ctrl[CB_MONITORED]),
        .reset_level(filt[IDX_RESET]),
        .accept(reset_accept)
    );

    // Millisecond time base
    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 16'h0001;
        if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            next_tick_cnt = 16'h0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_cnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // Both channels closed is the enabling condition for every type
    assign cond = filt[0] & filt[1];
    assign simul_active = ctrl[CB_SIMUL_EN] | (ctrl[CB_TYPE_HI:CB_TYPE_LO] != TYPE_TESTABLE);

    // Simultaneity supervision
    always_comb begin
        next_simul_cnt = simul_cnt;
        next_simul_fault = simul_fault;
        if (!simul_active || filt[0] == filt[1]) begin
            next_simul_cnt = 16'h0000;
        end else if (tick && simul_cnt != 16'hffff) begin
            next_simul_cnt = simul_cnt + 16'h0001;
        end
        if (simul_active && filt[0] != filt[1] && simul_cnt > simul_ms) begin
            next_simul_fault = 1'b1;
        end else if (~filt[0] & ~filt[1]) begin
            // Fault holds until both channels are back at rest
            next_simul_fault = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            simul_cnt <= 16'h0000;
            simul_fault <= 1'b0;
        end else begin
            simul_cnt <= next_simul_cnt;
            simul_fault <= next_simul_fault;
        end
    end

    // Output sequencing
    always_comb begin
        next_state = state;
        case (state)
            SIE_TEST_ON: begin
                // Next value, so a write in the first cycle after release still selects the test
                if (!next_ctrl[CB_POWERON_TEST]) begin
                    next_state = SIE_RUN;
                end else if (cond) begin
                    next_state = SIE_TEST_OFF;
                end
            end
            SIE_TEST_OFF: begin
                if (!cond) begin
                    next_state = ctrl[CB_RESET_EN] ? SIE_LOCK : SIE_RUN;
                end
            end
            SIE_RUN: begin
                if (ctrl[CB_RESET_EN] && !cond) begin
                    next_state = SIE_LOCK;
                end
            end
            SIE_LOCK: begin
                if (!ctrl[CB_RESET_EN]) begin
                    next_state = SIE_RUN;
                end else if (reset_accept && cond && !simul_fault) begin
                    next_state = SIE_RUN;
                end
            end
            default: next_state = SIE_TEST_ON;
        endcase
        next_block_out = (next_state == SIE_RUN) & cond & ~simul_fault;
        next_fault_out = ctrl[CB_ERR_OUT_EN] & simul_fault;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= SIE_TEST_ON;
            block_out <= 1'b0;
            fault_out <= 1'b0;
        end else begin
            state <= next_state;
            block_out <= next_block_out;
            fault_out <= next_fault_out;
        end
    end

    // Virtual inputs; basic master carries only the low byte
    always_comb begin
        next_vin = vin_out;
        if (fb_wr) begin
            if (ctrl[CB_FB_EXT]) begin
                next_vin = fb_data;
            end else begin
                next_vin = {{(VIN_EXT_W - VIN_BASIC_W){1'b0}}, fb_data[VIN_BASIC_W-1:0]};
            end
        end
    end

    // Registers, sticky status and interrupt
    always_comb begin
        events = '0;
        events[EV_SIMUL_ERR] = next_simul_fault & ~simul_fault;
        events[EV_OUT_RISE] = next_block_out & ~block_out;
        events[EV_OUT_FALL] = ~next_block_out & block_out;
        events[EV_RESET_OK] = reset_accept;
        next_ctrl = ctrl;
        next_filter_ms = filter_ms;
        next_simul_ms = simul_ms;
        next_mask = mask;
        next_status = status;
        if (reg_wr && hit(reg_addr, OFS_CTRL)) begin
            next_ctrl = reg_wdata[CTRL_W-1:0];
        end
        if (reg_wr && hit(reg_addr, OFS_FILTER)) begin
            next_filter_ms = reg_wdata[7:0];
        end
        if (reg_wr && hit(reg_addr, OFS_SIMUL)) begin
            next_simul_ms = reg_wdata[SIMUL_W-1:0];
        end
        if (reg_wr && hit(reg_addr, OFS_MASK)) begin
            next_mask = reg_wdata[EV_W-1:0];
        end
        if (reg_wr && hit(reg_addr, OFS_STATUS)) begin
            next_status = status & ~reg_wdata[EV_W-1:0];
        end
        // Set wins over a clear in the same cycle
        next_status = next_status | events;
        next_irq = |(next_status & next_mask);
        next_rdata = 32'h00000000;
        if (reg_rd) begin
            if (hit(reg_addr, OFS_CTRL)) next_rdata = {24'h000000, ctrl};
            else if (hit(reg_addr, OFS_FILTER)) next_rdata = {24'h000000, filter_ms};
            else if (hit(reg_addr, OFS_SIMUL)) next_rdata = {16'h0000, simul_ms};
            else if (hit(reg_addr, OFS_STATUS)) next_rdata = {28'h0000000, status};
            else if (hit(reg_addr, OFS_MASK)) next_rdata = {28'h0000000, mask};
            else if (hit(reg_addr, OFS_STATE)) next_rdata = {22'h000000, state, filt, simul_fault, fault_out, block_out, 1'b0};
            else if (hit(reg_addr, OFS_VIN)) next_rdata = vin_out;
            else next_rdata = 32'h00000000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl <= CTRL_RST;
            filter_ms <= FILTER_RST;
            simul_ms <= SIMUL_RST;
            mask <= '0;
            status <= '0;
            irq <= 1'b0;
            reg_rdata <= 32'h00000000;
            vin_out <= 32'h00000000;
            const_low_source <= 1'b0;
            const_high_source <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            filter_ms <= next_filter_ms;
            simul_ms <= next_simul_ms;
            mask <= next_mask;
            status <= next_status;
            irq <= next_irq;
            reg_rdata <= next_rdata;
            vin_out <= next_vin;
            // Fixed levels only; nothing here gates other logic
            const_low_source <= 1'b0;
            const_high_source <= 1'b1;
        end
    end
endmodule // sie_top

// ===== sie_pkg.sv
// Constants, register map and types for the safety input evaluation block
package sie_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 16;

    localparam int FILTER_MIN_MS = 3;
    localparam int FILTER_MAX_MS = 250;
    localparam logic [7:0] FILTER_MIN = 8'(FILTER_MIN_MS);
    localparam logic [7:0] FILTER_MAX = 8'(FILTER_MAX_MS);

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FILTER = 8'h04;
    localparam logic [7:0] OFS_SIMUL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [7:0] OFS_VIN = 8'h18;

    localparam int CTRL_W = 8;
    localparam int CB_RESET_EN = 0;
    localparam int CB_MONITORED = 1;
    localparam int CB_POWERON_TEST = 2;
    localparam int CB_SIMUL_EN = 3;
    localparam int CB_ERR_OUT_EN = 4;
    localparam int CB_TYPE_LO = 5;
    localparam int CB_TYPE_HI = 6;
    localparam int CB_FB_EXT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] FILTER_RST = 8'h03;
    localparam int SIMUL_W = 16;
    localparam logic [15:0] SIMUL_RST = 16'h00c8;

    localparam logic [1:0] TYPE_GRIP = 2'h0;
    localparam logic [1:0] TYPE_TESTABLE = 2'h1;
    localparam logic [1:0] TYPE_SOLID = 2'h2;

    localparam int EV_W = 4;
    localparam int EV_SIMUL_ERR = 0;
    localparam int EV_OUT_RISE = 1;
    localparam int EV_OUT_FALL = 2;
    localparam int EV_RESET_OK = 3;

    localparam int VIN_EXT_W = 32;
    localparam int VIN_BASIC_W = 8;
    localparam int NUM_IN = 4;
    localparam int IDX_RESET = 3;

    typedef enum logic [1:0] {
        SIE_TEST_ON = 2'b00,
        SIE_TEST_OFF = 2'b01,
        SIE_RUN = 2'b11,
        SIE_LOCK = 2'b10
    } sie_state_t;
endpackage

// ===== sie_debounce.sv
// Millisecond debounce filter for one synchronised input
module sie_debounce
    import sie_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [7:0] filter_ms,
    input wire logic din,
    output logic dout
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_dout;

    always_comb begin
        next_cnt = cnt;
        next_dout = dout;
        if (din == dout) begin
            next_cnt = 8'h00;
        end else if (tick) begin
            if (cnt + 8'h01 >= filter_ms) begin
                next_dout = din;
                next_cnt = 8'h00;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 8'h00;
            dout <= 1'b0;
        end else begin
            cnt <= next_cnt;
            dout <= next_dout;
        end
    end
endmodule // sie_debounce

// ===== sie_reset_ctl.sv
// Manual or monitored reset acceptance
module sie_reset_ctl
    import sie_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic monitored,
    input wire logic reset_level,
    output logic accept
);
    logic prev;
    logic seen_high;
    logic next_seen_high;
    logic next_accept;

    always_comb begin
        next_seen_high = seen_high;
        next_accept = 1'b0;
        if (!monitored) begin
            next_seen_high = 1'b0;
            next_accept = reset_level & ~prev;
        end else if (reset_level & ~prev) begin
            next_seen_high = 1'b1;
        end else if (~reset_level & prev & seen_high) begin
            next_seen_high = 1'b0;
            next_accept = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev <= 1'b0;
            seen_high <= 1'b0;
            accept <= 1'b0;
        end else begin
            prev <= reset_level;
            seen_high <= next_seen_high;
            accept <= next_accept;
        end
    end
endmodule // sie_reset_ctl

// ===== sie_top_chk.sv
// Port assertions for the safety input evaluation top
module sie_top_chk
    import sie_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic fb_wr,
    input wire logic [31:0] fb_data,
    input wire logic contact_input_a,
    input wire logic contact_input_b,
    input wire logic block_out,
    input wire logic fault_out,
    input wire logic [31:0] vin_out,
    input wire logic const_low_source,
    input wire logic const_high_source
);
    timeunit 1ns;
    timeprecision 1ps;
    // Tick phase may eat one of the three filter milliseconds
    localparam int LAG = 2 * TICK_CYCLES;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside the answer cycle");
    unmapped_zero_a: assert property (reg_rd && reg_addr > OFS_VIN |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    state_mirror_a: assert property (reg_rd && reg_addr == OFS_STATE |=>
        reg_rdata[2:0] == {$past(fault_out), $past(block_out), 1'b0})
        else $error("state word does not mirror outputs");
    const_low_a: assert property (const_low_source == 1'b0)
        else $error("low source not low");
    const_high_a: assert property (!$past(rst) |-> const_high_source)
        else $error("high source not high");
    vin_take_a: assert property (fb_wr |=> vin_out[7:0] == $past(fb_data[7:0]))
        else $error("virtual inputs not taken");
    vin_hold_a: assert property (!$past(fb_wr) |-> $stable(vin_out[7:0]))
        else $error("virtual inputs moved without update");
    debounce_rise_a: assert property ($rose(block_out) |->
        $past(contact_input_a, LAG) && $past(contact_input_b, LAG))
        else $error("output rose before contacts were stable");
endmodule // sie_top_chk

bind sie_top sie_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fb_wr(fb_wr), .fb_data(fb_data),
    .contact_input_a(contact_input_a), .contact_input_b(contact_input_b), .block_out(block_out),
    .fault_out(fault_out), .vin_out(vin_out), .const_low_source(const_low_source),
    .const_high_source(const_high_source));

// ===== sie_field.sv
// Field contacts and reset button with bounce and channel skew
module sie_field (
    input wire logic core_clk,
    input wire logic [3:0] tgt,
    input wire logic [7:0] skew,
    output logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bit 3 is the reset button, next after the contacts
    for (genvar i = 0; i < 4; i++) begin : g_ch
        initial begin
            pin[i] = 1'b0;
            forever begin
                @(posedge core_clk);
                if (pin[i] !== tgt[i]) begin
                    // Second channel lags
                    if (i == 1) repeat (skew) @(posedge core_clk);
                    // Bounce far shorter than any legal filter
                    repeat (3) begin
                        pin[i] <= ~pin[i];
                        @(posedge core_clk);
                    end
                    pin[i] <= tgt[i];
                end
            end
        end
    end
endmodule // sie_field

// ===== tb_sie_top.sv
// Self-checking bench for the safety input evaluation top
module tb_sie_top;
    import sie_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    typedef struct {logic [31:0] v; logic [31:0] m;} sie_exp_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fb_wr = 1'b0;
    logic probe = 1'b0;
    logic psel = 1'b0;
    logic rd_d = 1'b0;
    logic pr_d = 1'b0;
    logic ps_d = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] fb_data = 32'h0;
    logic [31:0] seed = 32'h109b7108;
    logic [3:0] tgt = 4'h0;
    logic [7:0] skew = 8'h0;
    logic [31:0] reg_rdata, vin_out, seen;
    logic block_out, fault_out, irq, c_lo, c_hi;
    logic [3:0] pin;
    sie_exp_t exp_q[$];
    sie_exp_t e;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [7:0] ra[8] = '{OFS_CTRL, OFS_FILTER, OFS_SIMUL, OFS_STATUS, OFS_MASK, OFS_VIN, 8'h1c, OFS_STATE};
    logic [31:0] rv[8] = '{32'(CTRL_RST), 32'(FILTER_RST), 32'(SIMUL_RST), 32'h0, 32'h0, 32'h0, 32'h0,
        {22'h0, SIE_RUN, 8'h0}};
    logic [3:0] pos[3] = '{4'h4, 4'h7, 4'h0};
    logic [7:0] sc[5] = '{8'h38, 8'h38, 8'h30, 8'h50, 8'h40};
    logic [7:0] ss[5] = '{8'h28, 8'h08, 8'h28, 8'h28, 8'h28};
    logic sf[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

    always #20 core_clk = ~core_clk;

    sie_top #(.TICK_CYCLES(TK)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .contact_input_a(pin[0]), .contact_input_b(pin[1]), .contact_input_c(pin[2]),
        .reset_input(pin[3]), .fb_wr(fb_wr), .fb_data(fb_data), .block_out(block_out),
        .fault_out(fault_out), .irq(irq), .vin_out(vin_out), .const_low_source(c_lo),
        .const_high_source(c_hi));
    sie_field u_field (.core_clk(core_clk), .tgt(tgt), .skew(skew), .pin(pin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic report_and_stop();
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back('{v, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    // Port probe: 0 picks the flag word, 1 the virtual inputs
    task automatic chk(input logic s, input logic [31:0] v, input logic [31:0] m);
        exp_q.push_back('{v, m});
        psel <= s;
        probe <= 1'b1;
        @(posedge core_clk);
        probe <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic ms(input int n);
        repeat (n * TK) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (rd_d || pr_d) begin
            seen = rd_d ? reg_rdata : (ps_d ? vin_out : {27'h0, c_lo, c_hi, irq, fault_out, block_out});
            e = exp_q.pop_front();
            cmp_count++;
            if ((seen & e.m) !== e.v) begin
                fails++;
                $display("[FAIL] %s expected %h seen %h", rd_d ? "reg_rdata" : "port word", e.v, seen & e.m);
            end
        end
        rd_d <= reg_rd;
        pr_d <= probe;
        ps_d <= psel;
        cyc++;
        if (cyc == 30000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i], 32'hffffffff);
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        // Test bit only counts if written in the first cycle
        wr(OFS_CTRL, 32'h1 << CB_POWERON_TEST);
        tgt <= 4'h7;
        ms(6);
        chk(1'b0, 32'h0, 32'h1);
        for (int i = 0; i < 3; i++) begin
            tgt <= pos[i];
            ms(6);
            chk(1'b0, {31'h0, i == 1}, 32'h1);
        end
        tgt <= 4'h7;
        ms(6);
        tgt <= 4'h6;
        @(posedge core_clk);
        tgt <= 4'h7;
        ms(6);
        chk(1'b0, 32'h1, 32'h1);
        wr(OFS_FILTER, 32'h14);
        tgt <= 4'h4;
        ms(12);
        chk(1'b0, 32'h1, 32'h1);
        ms(12);
        chk(1'b0, 32'h0, 32'h1);
        wr(OFS_FILTER, 32'h3);
        wr(OFS_SIMUL, 32'h5);
        wr(OFS_MASK, 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, {24'h0, sc[i]});
            // Both channels release together so the old fault clears
            skew <= 8'h0;
            tgt <= 4'h0;
            ms(5);
            wr(OFS_STATUS, 32'h1);
            skew <= ss[i];
            tgt <= 4'h3;
            ms(20);
            chk(1'b0, {29'h0, sf[i], sf[i] & sc[i][CB_ERR_OUT_EN], ~sf[i]}, 32'h7);
            rd(OFS_STATUS, {31'h0, sf[i]}, 32'h1);
        end
        wr(OFS_MASK, 32'h0);
        chk(1'b0, 32'h0, 32'h4);
        skew <= 8'h0;
        tgt <= 4'h0;
        ms(5);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_MASK, 32'h1);
        chk(1'b0, 32'h0, 32'h4);
        skew <= 8'h0;
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL, 32'h21 | (32'(m) << CB_MONITORED));
            tgt <= 4'h3;
            ms(6);
            tgt <= 4'h0;
            ms(6);
            tgt <= 4'h3;
            ms(6);
            chk(1'b0, 32'h0, 32'h1);
            tgt <= 4'hb;
            ms(6);
            chk(1'b0, {31'h0, m == 0}, 32'h1);
            tgt <= 4'h3;
            ms(6);
            chk(1'b0, 32'h1, 32'h1);
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, {24'h0, i[0], 7'h0});
            seed = xs(seed);
            fb_data <= seed;
            fb_wr <= 1'b1;
            @(posedge core_clk);
            fb_wr <= 1'b0;
            chk(1'b1, i[0] ? seed : {24'h0, seed[7:0]}, 32'hffffffff);
            rd(OFS_VIN, i[0] ? seed : {24'h0, seed[7:0]}, 32'hffffffff);
        end
        chk(1'b0, 32'h8, 32'h18);
        repeat (4) @(posedge core_clk);
        report_and_stop();
    end
endmodule // tb_sie_top
